// ---- src/mii_pin_mode_mux.sv ----
// mii pin mode mux: internal observation/gpio/wake versus external phy link
`timescale 1ns/1ps
// How it works
// (R1) internal mode: pins may show internal mii signals
// (R2) external mode: receive error is a phy input
// (R3) external mode: drive transmit error to phy
// (R4) external mode: drive transmit enable to phy
// (R5) external mode: phy drives receive data valid
// (R6) external mode: phy supplies receive clock
// (R7) external mode: phy supplies transmit clock
// (R8) external mode: phy drives carrier sense
// (R9) external mode: phy drives collision
// (R10) external mode: management data pin is bidirectional
// (R11) internal mode: shared pins usable as gpio
// (R12) wake mode: collision pin outputs wake event
// (R13) wake mode: management pin is wake mode select
// (R14) external mode: drive management clock to phy
// (R15) one mode select switches all pins together
module mii_pin_mode_mux
   import mii_mux_pkg::*;
(
   input wire logic clock,                            // 20 mhz system clock
   input wire logic reset,                            // synchronous reset, active high
   input wire logic ext_mode,                         // 1 external phy, 0 internal phy
   input wire logic wake_mode_en,                     // power-management-event mode on
   input wire logic [NPIN-1:0] observe_en,            // per pin: show internal signal
   input wire logic [NPIN-1:0] int_mii,               // internal mii signals to show
   input wire gpio_mode_t [NGPIO-1:0] gpio_mode,      // per gpio: function
   input wire logic [NGPIO-1:0] gpio_out,             // per gpio: output value
   output logic [NGPIO-1:0] gpio_in,                  // per gpio: synced pin level
   input wire logic wake_event_indication,            // wake event to signal out
   output logic wake_mode_select,                     // synced wake mode select input
   input wire mac_to_phy_t mac_out,                   // mac side toward external phy
   output phy_to_mac_t mac_in,                        // external phy toward mac
   input wire logic [NPIN-1:0] pin_i,                 // pad input levels
   output logic [NPIN-1:0] pin_o,                     // pad output values
   output logic [NPIN-1:0] pin_oe_n                   // pad output enable, low drives
);

   // whole state in one record
   typedef struct packed {
      logic ext;                 // registered mode, one select for all pins
      logic [NPIN-1:0] pin_o;    // pad outputs
      logic [NPIN-1:0] pin_oe_n; // pad enables
      phy_to_mac_t mac_in;       // inputs handed to the mac
      logic [NGPIO-1:0] gpio_in; // gpio readback
      logic wake_sel;            // wake mode select readback
   } mux_state_t;

   mux_state_t s_q;  // registered state
   mux_state_t s_d;  // next state
   logic [NPIN-1:0] lvl;   // synchronised pad levels
   logic [NPIN-1:0] rise;  // rising edge pulses of pad levels

   // every pad input crosses two flip-flops before use, link clocks included
   pin_sync #(.WIDTH(NPIN)) u_sync (
      .clock(clock),
      .reset(reset),
      .async_i(pin_i),
      .level(lvl),
      .rise(rise)
   );

   // next pin and readback values, all chosen from the one registered mode
   always_comb begin
      s_d = s_q;
      s_d.ext = ext_mode; // [R15]
      s_d.pin_o = OUT_RESET;
      s_d.pin_oe_n = OE_N_RESET;
      s_d.mac_in = '0;
      s_d.gpio_in = '0;
      s_d.wake_sel = 1'b0;
      if (s_q.ext) begin
         // external phy: fixed directions except management data, gpio and wake functions gone [R15]
         s_d.pin_o[P_TXER] = mac_out.tx_er; // [R3]
         s_d.pin_oe_n[P_TXER] = 1'b0; // [R3]
         s_d.pin_o[P_TXEN] = mac_out.tx_en; // [R4]
         s_d.pin_oe_n[P_TXEN] = 1'b0; // [R4]
         s_d.pin_o[P_MDC] = mac_out.mdc; // [R14]
         s_d.pin_oe_n[P_MDC] = 1'b0; // [R14]
         // management data turns round under mac control
         s_d.pin_o[P_MDIO] = mac_out.mdio_o; // [R10]
         s_d.pin_oe_n[P_MDIO] = ~mac_out.mdio_drive; // [R10]
         s_d.mac_in.mdio_i = lvl[P_MDIO]; // [R10]
         // phy-driven inputs; pads stay released
         s_d.mac_in.rx_er = lvl[P_RXER]; // [R2]
         s_d.mac_in.rx_dv = lvl[P_RXDV]; // [R5]
         s_d.mac_in.rx_clk = lvl[P_RXCLK]; // [R6]
         s_d.mac_in.rx_clk_rise = rise[P_RXCLK]; // [R6]
         s_d.mac_in.tx_clk = lvl[P_TXCLK]; // [R7]
         s_d.mac_in.tx_clk_rise = rise[P_TXCLK]; // [R7]
         s_d.mac_in.crs = lvl[P_CRS]; // [R8]
         s_d.mac_in.col = lvl[P_COL]; // [R9]
      end else begin
         // internal phy: observation first, shared pins may be overridden
         for (int p = 0; p < NPIN; p++) begin
            if (observe_en[p]) begin
               s_d.pin_o[p] = int_mii[p]; // [R1]
               s_d.pin_oe_n[p] = 1'b0; // [R1]
            end
         end
         // gpio functions take the shared pin away from observation
         for (int g = 0; g < NGPIO; g++) begin
            s_d.gpio_in[g] = lvl[GPIO_PIN[g]]; // [R11]
            unique case (gpio_mode[g])
               GPIO_OFF: begin
                  // pin keeps whatever observation chose
               end
               GPIO_IN: begin
                  s_d.pin_o[GPIO_PIN[g]] = 1'b0; // [R11]
                  s_d.pin_oe_n[GPIO_PIN[g]] = 1'b1; // [R11]
               end
               GPIO_PP: begin
                  s_d.pin_o[GPIO_PIN[g]] = gpio_out[g]; // [R11]
                  s_d.pin_oe_n[GPIO_PIN[g]] = 1'b0; // [R11]
               end
               GPIO_OD: begin
                  // only ever pulls low; a one releases the pad
                  s_d.pin_o[GPIO_PIN[g]] = 1'b0; // [R11]
                  s_d.pin_oe_n[GPIO_PIN[g]] = gpio_out[g]; // [R11]
               end
            endcase
         end
         // wake mode wins over gpio on the two pins it claims
         if (wake_mode_en) begin
            s_d.pin_o[P_COL] = wake_event_indication; // [R12]
            s_d.pin_oe_n[P_COL] = 1'b0; // [R12]
            s_d.pin_o[P_MDIO] = 1'b0; // [R13]
            s_d.pin_oe_n[P_MDIO] = 1'b1; // [R13]
            s_d.wake_sel = lvl[P_MDIO]; // [R13]
         end
      end
   end

   // register the state; reset releases every pad
   always_ff @(posedge clock) begin
      if (reset) begin
         s_q <= '0;
         s_q.pin_oe_n <= OE_N_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   assign pin_o = s_q.pin_o;
   assign pin_oe_n = s_q.pin_oe_n;
   assign mac_in = s_q.mac_in;
   assign gpio_in = s_q.gpio_in;
   assign wake_mode_select = s_q.wake_sel;

   // checks on the pad behaviour
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   AST_R1_OBSERVE: assert property ( // [R1]
      (!s_q.ext && observe_en[P_TXEN]) |=>
         (!pin_oe_n[P_TXEN] && pin_o[P_TXEN] == $past(int_mii[P_TXEN])))
      else $error("internal signal not shown on transmit enable pin");

   // pads follow the registered mode one edge later, so the check looks one cycle on
   AST_R2_RXER: assert property ( // [R2]
      s_q.ext |=> pin_oe_n[P_RXER])
      else $error("receive error pin driven in external mode");

   AST_R2_RXER_IN: assert property ( // [R2]
      s_q.ext |=> (mac_in.rx_er == $past(lvl[P_RXER])))
      else $error("receive error not passed to mac");

   AST_R5_RXDV: assert property ( // [R5]
      s_q.ext |=> (mac_in.rx_dv == $past(lvl[P_RXDV])))
      else $error("receive data valid not passed to mac");

   AST_R3_TXER: assert property ( // [R3]
      s_q.ext |=> (!pin_oe_n[P_TXER] && pin_o[P_TXER] == $past(mac_out.tx_er)))
      else $error("transmit error not driven to phy");

   AST_R4_TXEN: assert property ( // [R4]
      (s_q.ext && mac_out.tx_en) ##1 s_q.ext |-> (!pin_oe_n[P_TXEN] && pin_o[P_TXEN]))
      else $error("transmit enable not driven to phy");

   AST_R6_RXCLK: assert property ( // [R6]
      (s_q.ext && rise[P_RXCLK]) |=> mac_in.rx_clk_rise ##1 !mac_in.rx_clk_rise)
      else $error("receive clock edge not one pulse");

   AST_R7_TXCLK: assert property ( // [R7]
      (s_q.ext && rise[P_TXCLK]) |=> mac_in.tx_clk_rise ##1 !mac_in.tx_clk_rise)
      else $error("transmit clock edge not one pulse");

   AST_R8_R9_SENSE: assert property ( // [R8] [R9]
      s_q.ext |=> (mac_in.crs == $past(lvl[P_CRS]) && mac_in.col == $past(lvl[P_COL])))
      else $error("carrier or collision not passed to mac");

   AST_R10_MDIO: assert property ( // [R10]
      s_q.ext |=> (pin_oe_n[P_MDIO] == !$past(mac_out.mdio_drive)
                   && mac_in.mdio_i == $past(lvl[P_MDIO])))
      else $error("management data direction wrong");

   AST_R11_OD: assert property ( // [R11]
      (!s_q.ext && !wake_mode_en && gpio_mode[G_ONE] == GPIO_OD) |=>
         (!pin_o[P_MDIO] && pin_oe_n[P_MDIO] == $past(gpio_out[G_ONE])))
      else $error("open-drain gpio drives high");

   AST_R12_WAKE: assert property ( // [R12]
      (!s_q.ext && wake_mode_en) |=>
         (!pin_oe_n[P_COL] && pin_o[P_COL] == $past(wake_event_indication)))
      else $error("wake event not on collision pin");

   AST_R13_SEL: assert property ( // [R13]
      (!s_q.ext && wake_mode_en) |=>
         (pin_oe_n[P_MDIO] && wake_mode_select == $past(lvl[P_MDIO])))
      else $error("wake mode select not sampled");

   AST_R14_MDC: assert property ( // [R14]
      s_q.ext |=> (!pin_oe_n[P_MDC] && pin_o[P_MDC] == $past(mac_out.mdc)))
      else $error("management clock not driven");

   AST_R15_SWITCH: assert property ( // [R15]
      (ext_mode && !s_q.ext) |=> ##1
         (pin_oe_n[P_RXDV] && pin_oe_n[P_CRS] && pin_oe_n[P_COL] && gpio_in == '0))
      else $error("mixed configuration after switch to external mode");

   COV_EXT_TX: cover property (s_q.ext && !pin_oe_n[P_TXEN] && pin_o[P_TXEN]);
   COV_GPIO_PP: cover property (!s_q.ext && gpio_mode[G_ONE] == GPIO_PP ##1 !pin_oe_n[P_MDIO]);
   COV_WAKE: cover property (!s_q.ext && wake_mode_en ##1 pin_o[P_COL]);
   COV_GPIO_OD: cover property (!s_q.ext && gpio_mode[G_ONE] == GPIO_OD ##1 !pin_oe_n[P_MDIO]);
   COV_SWITCH: cover property ($rose(s_q.ext) ##2 mac_in.rx_clk_rise);

endmodule : mii_pin_mode_mux

// ---- src/mii_mux_pkg.sv ----
// shared pin indices, field types and reset values for the mii pin mode mux
package mii_mux_pkg;

   // pin slots in the pin_i / pin_o / pin_oe_n vectors
   localparam int NPIN = 10;      // number of multiplexed pins
   localparam int P_RXER = 0;     // receive error
   localparam int P_TXER = 1;     // transmit error
   localparam int P_TXEN = 2;     // transmit enable
   localparam int P_RXDV = 3;     // receive data valid
   localparam int P_RXCLK = 4;    // receive clock
   localparam int P_TXCLK = 5;    // transmit clock
   localparam int P_CRS = 6;      // carrier sense, also general_pin_three
   localparam int P_COL = 7;      // collision, also general_pin_zero
   localparam int P_MDIO = 8;     // management data, also general_pin_one
   localparam int P_MDC = 9;      // management clock

   // general purpose slots and the pins they share
   localparam int NGPIO = 3;      // number of general purpose pins
   localparam int G_ZERO = 0;     // general_pin_zero slot
   localparam int G_ONE = 1;      // general_pin_one slot
   localparam int G_THREE = 2;    // general_pin_three slot
   localparam int GPIO_PIN [NGPIO] = '{P_COL, P_MDIO, P_CRS};

   // reset values
   localparam logic [NPIN-1:0] OE_N_RESET = 10'h3ff;  // every pin released
   localparam logic [NPIN-1:0] OUT_RESET = 10'h000;   // every pin output low

   // general purpose pin function
   typedef enum logic [1:0] {
      GPIO_OFF,    // pin keeps its mii observation function
      GPIO_IN,     // schmitt input
      GPIO_PP,     // push-pull output
      GPIO_OD      // open-drain output
   } gpio_mode_t;

   // signals the mac drives toward an external phy
   typedef struct packed {
      logic tx_en;       // transmit enable
      logic tx_er;       // transmit error
      logic mdc;         // management clock
      logic mdio_o;      // management data out
      logic mdio_drive;  // high while the mac owns the management data line
   } mac_to_phy_t;

   // signals an external phy hands to the mac, already synchronised
   typedef struct packed {
      logic rx_er;        // receive error
      logic rx_dv;        // receive data valid
      logic crs;          // carrier sense
      logic col;          // collision
      logic mdio_i;       // management data in
      logic rx_clk;       // receive clock level
      logic rx_clk_rise;  // one-cycle pulse per receive clock rising edge
      logic tx_clk;       // transmit clock level
      logic tx_clk_rise;  // one-cycle pulse per transmit clock rising edge
   } phy_to_mac_t;

endpackage : mii_mux_pkg

// ---- src/pin_sync.sv ----
// two-stage synchroniser with rising edge detection for pin inputs
`timescale 1ns/1ps
module pin_sync #(
   parameter int WIDTH = 10  // number of pins sampled
) (
   input wire logic clock,               // system clock
   input wire logic reset,               // synchronous reset, active high
   input wire logic [WIDTH-1:0] async_i, // raw pin levels
   output logic [WIDTH-1:0] level,       // synchronised level
   output logic [WIDTH-1:0] rise         // one-cycle pulse on a rising level
);

   // whole state in one record
   typedef struct packed {
      logic [WIDTH-1:0] meta;    // first stage, read only by the second
      logic [WIDTH-1:0] stable;  // second stage, safe to use
      logic [WIDTH-1:0] prev;    // stable delayed for edge finding
      logic [WIDTH-1:0] rise;    // registered edge pulse
      logic [2:0] warm;          // fills with ones after reset; edges trusted once full
   } sync_state_t;

   sync_state_t s_q;  // registered state
   sync_state_t s_d;  // next state

   // shift chain; edge taken from stable stages only, never from meta
   always_comb begin
      s_d = s_q;
      s_d.meta = async_i;
      s_d.stable = s_q.meta;
      s_d.prev = s_q.stable;
      s_d.warm = {s_q.warm[1:0], 1'b1};
      // reset zeroes the stages, so a pad idling high would look like a rising edge;
      // edges are held off until prev holds a real pad sample
      s_d.rise = s_q.stable & ~s_q.prev & {WIDTH{s_q.warm[2]}};
   end

   // register the state
   always_ff @(posedge clock) begin
      if (reset) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign level = s_q.stable;
   assign rise = s_q.rise;

endmodule : pin_sync

// ---- sim/phy_model.sv ----
// external phy model: drives its mii outputs and resolves the shared pads
`timescale 1ns/1ps
module phy_model
   import mii_mux_pkg::*;
(
   input wire logic present,              // phy fitted and powered
   input wire logic [3:0] sig,            // rx_er, rx_dv, crs, col levels
   input wire logic mdio_drv,             // phy owns management data
   input wire logic mdio_val,             // phy management data value
   input wire logic clk_run,              // link clocks run
   input wire logic [NPIN-1:0] pin_o,     // device pad values
   input wire logic [NPIN-1:0] pin_oe_n,  // device pad enables, low drives
   output logic [NPIN-1:0] pin_i          // resolved pad levels
);
   // released pads settle on their pull, never on a stale value
   localparam logic [NPIN-1:0] PULL = 10'h3e0;
   logic rxc = 1'b0;  // receive clock, stands still between runs
   logic [NPIN-1:0] drv;  // phy drive enables
   logic [NPIN-1:0] val;  // phy drive values
   // link clocks toggle while running and finish the half period under way at stop; transmit clock is the complement
   always begin
      wait (clk_run);
      #200 rxc = ~rxc;
   end
   // phy outputs toward the device
   always_comb begin
      drv = '0;
      val = '0;
      if (present) begin
         drv = 10'h0f9;
         drv[P_MDIO] = mdio_drv;
      end
      val[P_RXER] = sig[3];
      val[P_RXDV] = sig[2];
      val[P_CRS] = sig[1];
      val[P_COL] = sig[0];
      val[P_RXCLK] = rxc;
      val[P_TXCLK] = ~rxc;
      val[P_MDIO] = mdio_val;
   end
   // wire level: device drive, else phy drive, else pull
   assign pin_i = (~pin_oe_n & pin_o) | (pin_oe_n & drv & val) | (pin_oe_n & ~drv & PULL);
endmodule : phy_model

// ---- sim/tb_top.sv ----
// self-checking bench for the mii pin mode mux with an external phy model
`timescale 1ns/1ps
module tb_top;
   import mii_mux_pkg::*;
   typedef gpio_mode_t [NGPIO-1:0] gmv_t;
   // one row: inputs, then expected pad enables and values
   typedef struct packed {
      logic ext;
      logic wake;
      logic [9:0] obs;
      logic [9:0] mii;
      gmv_t gm;
      logic [2:0] go;
      logic evt;
      logic [4:0] mac;
      logic [9:0] oe;
      logic [9:0] o;
   } row_t;
   row_t rows [7];
   logic clock = 1'b0, reset = 1'b1, ext_mode = 1'b0, wake_mode_en = 1'b0;
   logic [NPIN-1:0] observe_en = '0, int_mii = '0, pin_i, pin_o, pin_oe_n;
   gmv_t gpio_mode = '0;
   logic [NGPIO-1:0] gpio_out = '0, gpio_in;
   logic wake_event_indication = 1'b0, wake_mode_select;
   mac_to_phy_t mac_out = '0;
   phy_to_mac_t mac_in;
   logic present = 1'b0, mdio_drv = 1'b0, mdio_val = 1'b0, clk_run = 1'b0;
   logic [3:0] sig = '0;  // rx_er, rx_dv, crs, col
   int n_mismatch = 0, checks = 0, n_rx = 0, n_tx = 0, a_rx, a_tx;
   always #25 clock = ~clock;
   mii_pin_mode_mux i_dut (.clock(clock), .reset(reset), .ext_mode(ext_mode),
      .wake_mode_en(wake_mode_en), .observe_en(observe_en), .int_mii(int_mii),
      .gpio_mode(gpio_mode), .gpio_out(gpio_out), .gpio_in(gpio_in),
      .wake_event_indication(wake_event_indication), .wake_mode_select(wake_mode_select),
      .mac_out(mac_out), .mac_in(mac_in), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_n(pin_oe_n));
   phy_model i_phy (.present(present), .sig(sig), .mdio_drv(mdio_drv), .mdio_val(mdio_val),
      .clk_run(clk_run), .pin_o(pin_o), .pin_oe_n(pin_oe_n), .pin_i(pin_i));
   // count link clock edges seen by the mac side; pulses last one cycle
   always @(posedge clock) begin
      if (!reset) begin
         n_rx <= n_rx + 32'(mac_in.rx_clk_rise);
         n_tx <= n_tx + 32'(mac_in.tx_clk_rise);
      end
   end
   task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // two flops plus the output register, with two cycles to spare
   task automatic settle;
      repeat (5) @(posedge clock);
      #1;
   endtask : settle
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : tally_and_finish
   // a hang ends here as a mismatch
   initial begin
      #1000000;
      n_mismatch++;
      tally_and_finish();
   end
   initial begin
      // ext wake obs mii gm go evt mac oe o
      rows[0] = {2'b00, 10'h3ff, 10'h2a5, 6'h00, 3'h0, 1'b0, 5'h00, 10'h000, 10'h2a5};
      rows[1] = {2'b00, 10'h000, 10'h3ff, 6'h00, 3'h0, 1'b0, 5'h00, 10'h3ff, 10'h000};
      rows[2] = {2'b10, 10'h3ff, 10'h000, 6'h00, 3'h0, 1'b0, 5'h17, 10'h0f9, 10'h304};
      rows[3] = {2'b10, 10'h000, 10'h000, 6'h00, 3'h0, 1'b0, 5'h08, 10'h1f9, 10'h002};
      rows[4] = {2'b00, 10'h000, 10'h000, 6'h1e, 3'h1, 1'b0, 5'h00, 10'h27f, 10'h080};
      rows[5] = {2'b01, 10'h000, 10'h000, 6'h2a, 3'h4, 1'b1, 5'h00, 10'h33f, 10'h0c0};
      rows[6] = {2'b11, 10'h3ff, 10'h3ff, 6'h2a, 3'h7, 1'b1, 5'h01, 10'h0f9, 10'h000};
      repeat (3) @(posedge clock);
      reset <= 1'b0;
      #1 chk("pin_oe_n", 10'h3ff, pin_oe_n);
      // output side of every mode through the table
      foreach (rows[i]) begin
         @(posedge clock);
         {ext_mode, wake_mode_en, observe_en, int_mii} <= {rows[i].ext, rows[i].wake,
            rows[i].obs, rows[i].mii};
         {gpio_mode, gpio_out, wake_event_indication} <= {rows[i].gm, rows[i].go, rows[i].evt};
         mac_out <= rows[i].mac;
         present <= rows[i].ext;
         settle();
         chk("pin_oe_n", rows[i].oe, pin_oe_n);
         chk("pin_o", rows[i].o & ~rows[i].oe, pin_o & ~rows[i].oe);
      end
      // phy inputs reach the mac; management line released by the mac
      @(posedge clock);
      mac_out <= '0;
      mdio_drv <= 1'b1;
      for (int k = 0; k < 2; k++) begin
         @(posedge clock);
         sig <= k ? 4'b0101 : 4'b1010;
         mdio_val <= k[0];
         settle();
         // link clocks stand still here: receive low, transmit its complement
         chk("mac_in", {3'h0, 2'b01, sig, mdio_val}, {3'h0, mac_in.rx_clk, mac_in.tx_clk,
            mac_in.rx_er, mac_in.rx_dv, mac_in.crs, mac_in.col,
            mac_in.mdio_i});
      end
      // twenty link clock periods, phase unrelated to the system clock
      a_rx = n_rx;
      a_tx = n_tx;
      #13 clk_run = 1'b1;
      #7900 clk_run = 1'b0;
      repeat (20) @(posedge clock);
      chk("rx_clk rises", 10'd20, 10'(n_rx - a_rx));
      chk("tx_clk rises", 10'd20, 10'(n_tx - a_tx));
      // internal mode: shared pads read back as inputs, mac side held quiet
      @(posedge clock);
      {ext_mode, wake_mode_en, observe_en, gpio_mode} <= {2'b00, 10'h000, 6'h15};
      sig <= 4'b0010;
      mdio_val <= 1'b1;
      settle();
      chk("gpio_in", 10'h006, {7'h0, gpio_in});
      chk("mac_in crs", 10'h000, {9'h0, mac_in.crs});
      @(posedge clock);
      wake_mode_en <= 1'b1;
      mdio_val <= 1'b0;
      settle();
      chk("wake_mode_select", 10'h000, {9'h0, wake_mode_select});
      @(posedge clock);
      mdio_val <= 1'b1;
      settle();
      chk("wake_mode_select", 10'h001, {9'h0, wake_mode_select});
      // second reset in mid-run releases every pad
      @(posedge clock);
      reset <= 1'b1;
      repeat (2) @(posedge clock);
      #1 chk("pin_oe_n", 10'h3ff, pin_oe_n);
      tally_and_finish();
   end
endmodule : tb_top
